// [pmcc_pkg.sv]
// package for the power mode and clock control block: offsets, layouts,
// reset values, state and mode enumerations, timing constants.
// assumes a single 125 MHz clock and a plain register port.
`default_nettype none

package pmcc_pkg;

   // -------------------------------------------------------------------
   // timing
   // -------------------------------------------------------------------
   localparam int CLK_MHZ       = 125;
   localparam int RST_PULSE_NS  = 800;
   localparam int RST_PULSE_CYC = (RST_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_W         = 8;
   localparam logic [CNT_W-1:0] RST_PULSE_CNT = CNT_W'(RST_PULSE_CYC);

   // -------------------------------------------------------------------
   // register map
   // -------------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFS_CLKCFG = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_LPCFG  = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
   localparam int BIT_CSS_FLAG  = 0;
   localparam int BIT_WAKE_FLAG = 1;

   // -------------------------------------------------------------------
   // enumerations
   // -------------------------------------------------------------------
   typedef enum logic [1:0] {
      SRC_INTERNAL_FAST_OSCILLATOR,
      SRC_EXTERNAL_FAST_OSCILLATOR,
      SRC_MULTIPLIER_LOOP_CLOCK
   } pmcc_src_t;

   typedef enum logic [1:0] {
      REG_MAIN_REGULATOR_MODE,
      REG_LOW_POWER_REGULATOR_MODE,
      REG_HIGH_IMPEDANCE
   } pmcc_reg_t;

   typedef enum logic [1:0] {
      LP_SLEEP,
      LP_STOP,
      LP_STANDBY
   } pmcc_lp_t;

   typedef enum logic [2:0] {
      ST_RESET,
      ST_RUN,
      ST_SLEEP,
      ST_STOP,
      ST_STANDBY
   } pmcc_state_t;

   // -------------------------------------------------------------------
   // layouts
   // -------------------------------------------------------------------
   typedef struct packed {
      logic [2:0] apb2_div;
      logic [2:0] apb1_div;
      logic [3:0] ahb_div;
      logic [3:0] pll_div;
      logic [3:0] pll_mul;
      logic       pll_src_ext;
      pmcc_src_t  root_src;
   } pmcc_clk_cfg_t;

   typedef struct packed {
      logic      css_ie;
      logic      stop_lpr;
      pmcc_lp_t  mode;
   } pmcc_lp_cfg_t;

   typedef struct packed {
      pmcc_state_t state;
      pmcc_src_t   active_src;
      logic        wake_flag;
      logic        css_flag;
   } pmcc_status_t;

   typedef struct packed {
      logic      core_clk_en;
      logic      domain_clk_en;
      logic      core_power;
      logic      retain;
      logic      int_osc_en;
      logic      ext_osc_en;
      logic      loop_en;
      pmcc_reg_t regulator;
   } pmcc_pwr_t;

   localparam int CLKCFG_W = $bits(pmcc_clk_cfg_t);
   localparam int LPCFG_W  = $bits(pmcc_lp_cfg_t);
   localparam pmcc_clk_cfg_t CLKCFG_RST = '0;
   localparam pmcc_lp_cfg_t  LPCFG_RST  = '0;

   // raw pin vector: 16 lines plus 7 single events
   localparam int LINES  = 16;
   localparam int SYNC_W = LINES + 7;

endpackage

`default_nettype wire

// [pmcc_div.sv]
// prescaler producing a one-cycle tick every (div+1) source ticks.
// assumes the source tick and the divide value are on the same clock.
`default_nettype none
`timescale 1ns/100ps

module pmcc_div
#(
   parameter int W = 4
)
(
   // clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_external_reset_pin,
   // source
   input  wire logic         i_en,
   input  wire logic [W-1:0] i_div,
   // derived tick
   output logic              o_tick
);

   logic [W-1:0] cnt;
   logic [W-1:0] next_cnt;
   logic         next_tick;

   // -------------------------------------------------------------------
   // counter
   // -------------------------------------------------------------------
   always_comb
   begin
      next_cnt  = cnt;
      next_tick = 1'b0;
      if (i_en)
      begin
         // a divide change mid-count takes effect at once; a count at or past the new value wraps on the next source tick
         if (cnt >= i_div)
         begin
            next_cnt  = '0;
            next_tick = 1'b1;
         end
         else
         begin
            next_cnt = cnt + W'(1);
         end
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_external_reset_pin)
      begin
         cnt    <= '0;
         o_tick <= 1'b0;
      end
      else
      begin
         cnt    <= next_cnt;
         o_tick <= next_tick;
      end
   end

endmodule // pmcc_div

`default_nettype wire

// [pmcc_top.sv]
// power mode and clock control: root clock choice, bus prescalers,
// low-power sequencing, reset hold on low supply.
// assumes pins arrive asynchronously and the core request is on i_clk.
//
// Contract
// - system reset is held while the supply monitor reports low voltage.
// - regulator runs main in run, low power in stop when stop_lpr is set (main otherwise), high-z in standby.
// - regulator is active after any reset and goes high-z only in standby.
// - sleep halts only the core clock and any interrupt returns to run.
// - stop gates the domain clock and all fast oscillators, keeps data.
// - stop ends on any of the 16 external lines or a calendar event.
// - standby powers off the core domain and stops all fast clocks.
// - standby ends on reset pin, watchdog, wake pin rise or calendar event.
// - after reset the internal fast oscillator drives the root clock.
// - root clock picks internal, external or loop; loop ref is selectable.
// - external oscillator failure forces internal source and flags an irq.
// - bus clock ticks divide root, and each peripheral tick divides bus.
`default_nettype none
`timescale 1ns/100ps

module pmcc_top
(
   // clock and reset
   input  wire logic                          i_clk,
   input  wire logic                          i_external_reset_pin,
   // register port
   input  wire logic [pmcc_pkg::ADDR_W-1:0]   i_addr,
   input  wire logic [31:0]                   i_wdata,
   input  wire logic                          i_wr,
   input  wire logic                          i_rd,
   output logic [31:0]                        o_rdata,
   // core request
   input  wire logic                          i_lp_req,
   // asynchronous pins and events
   input  wire logic                          i_supply_low,
   input  wire logic                          i_external_reset_pin_n,
   input  wire logic                          i_independent_watchdog,
   input  wire logic                          i_wake_pin,
   input  wire logic                          i_rtc_event,
   input  wire logic                          i_ext_osc_fail,
   input  wire logic                          i_irq_event,
   input  wire logic [pmcc_pkg::LINES-1:0]    i_ext_lines,
   // reset, power and clock control
   output logic                               o_sys_rst_n,
   output pmcc_pkg::pmcc_pwr_t                o_pwr,
   output pmcc_pkg::pmcc_clk_cfg_t            o_clk_cfg,
   output logic                               o_css_irq,
   // bus ticks
   output logic                               o_ahb_tick,
   output logic                               o_apb1_tick,
   output logic                               o_apb2_tick
);

   import pmcc_pkg::*;

   // -------------------------------------------------------------------
   // pin synchronisers
   // -------------------------------------------------------------------
   logic [SYNC_W-1:0] raw;
   logic [SYNC_W-1:0] meta;
   logic [SYNC_W-1:0] stable;
   logic              wake_prev;

   // reset pin inverted ahead of the first flop so all bits are active high
   assign raw = {i_supply_low, ~i_external_reset_pin_n,
                 i_independent_watchdog, i_wake_pin, i_rtc_event,
                 i_ext_osc_fail, i_irq_event, i_ext_lines};

   genvar g;
   generate
      for (g = 0; g < SYNC_W; g = g + 1)
      begin : g_sync
         always_ff @(posedge i_clk)
         begin
            if (!i_external_reset_pin)
            begin
               meta[g]   <= 1'b0;
               stable[g] <= 1'b0;
            end
            else
            begin
               meta[g]   <= raw[g];
               stable[g] <= meta[g];
            end
         end
      end
   endgenerate

   logic             s_supply_low;
   logic             s_ext_rst;
   logic             s_wdg;
   logic             s_wake;
   logic             s_rtc;
   logic             s_fail;
   logic             s_irq;
   logic [LINES-1:0] s_lines;

   assign {s_supply_low, s_ext_rst, s_wdg, s_wake, s_rtc, s_fail, s_irq,
           s_lines} = stable;

   // -------------------------------------------------------------------
   // power sequencer
   // -------------------------------------------------------------------
   pmcc_state_t  state;
   pmcc_state_t  next_state;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic         next_wake_flag;
   logic         wake_flag;
   logic         hard_rst;
   logic         wake_rise;
   pmcc_clk_cfg_t clk_cfg;
   pmcc_lp_cfg_t  lp_cfg;

   assign hard_rst  = s_supply_low | s_ext_rst | s_wdg;
   assign wake_rise = s_wake & ~wake_prev;

   always_comb
   begin
      next_state     = state;
      next_cnt       = cnt;
      next_wake_flag = wake_flag;
      case (state)
         ST_RESET:
         begin
            if (cnt != '0)
               next_cnt = cnt - CNT_W'(1);
            else
               next_state = ST_RUN;
         end
         ST_RUN:
         begin
            if (i_lp_req)
            begin
               case (lp_cfg.mode)
                  LP_STOP:    next_state = ST_STOP;
                  LP_STANDBY: next_state = ST_STANDBY;
                  default:    next_state = ST_SLEEP;
               endcase
            end
         end
         ST_SLEEP:
         begin
            if (s_irq)
               next_state = ST_RUN;
         end
         ST_STOP:
         begin
            if ((|s_lines) || s_rtc)
               next_state = ST_RUN;
         end
         ST_STANDBY:
         begin
            if (wake_rise || s_rtc)
            begin
               next_state     = ST_RESET;
               next_cnt       = RST_PULSE_CNT;
               next_wake_flag = 1'b1;
            end
         end
         default:
         begin
            next_state = ST_RESET;
            next_cnt   = RST_PULSE_CNT;
         end
      endcase
      // pin and watchdog resets also end standby; low supply holds reset
      if (hard_rst)
      begin
         next_state = ST_RESET;
         next_cnt   = RST_PULSE_CNT;
      end
      // a set from low wins over a same-cycle clear
      if (i_wr && i_addr == OFS_STATUS && i_wdata[BIT_WAKE_FLAG]
          && next_wake_flag == wake_flag)
         next_wake_flag = 1'b0;
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_external_reset_pin)
      begin
         state     <= ST_RESET;
         cnt       <= RST_PULSE_CNT;
         wake_flag <= 1'b0;
         wake_prev <= 1'b0;
      end
      else
      begin
         state     <= next_state;
         cnt       <= next_cnt;
         wake_flag <= next_wake_flag;
         wake_prev <= s_wake;
      end
   end

   // -------------------------------------------------------------------
   // register file and clock switching
   // -------------------------------------------------------------------
   pmcc_clk_cfg_t next_clk_cfg;
   pmcc_lp_cfg_t  next_lp_cfg;
   logic          css_flag;
   logic          next_css_flag;
   logic [31:0]   next_rdata;
   logic          uses_ext;
   logic          soft_rst;
   pmcc_status_t  status;

   assign soft_rst = (state == ST_RESET);
   assign uses_ext = (clk_cfg.root_src == SRC_EXTERNAL_FAST_OSCILLATOR) ||
                     (clk_cfg.root_src == SRC_MULTIPLIER_LOOP_CLOCK &&
                      clk_cfg.pll_src_ext);
   assign status   = '{state: state, active_src: clk_cfg.root_src,
                       wake_flag: wake_flag, css_flag: css_flag};

   always_comb
   begin
      next_clk_cfg  = clk_cfg;
      next_lp_cfg   = lp_cfg;
      next_css_flag = css_flag;
      next_rdata    = '0;
      if (i_wr && i_addr == OFS_CLKCFG)
         next_clk_cfg = pmcc_clk_cfg_t'(i_wdata[CLKCFG_W-1:0]);
      else if (i_wr && i_addr == OFS_LPCFG)
         next_lp_cfg = pmcc_lp_cfg_t'(i_wdata[LPCFG_W-1:0]);
      else if (i_wr && i_addr == OFS_STATUS && i_wdata[BIT_CSS_FLAG])
         next_css_flag = 1'b0;
      // an unused source code falls back to the internal oscillator
      if (next_clk_cfg.root_src == 2'h3)
         next_clk_cfg.root_src = SRC_INTERNAL_FAST_OSCILLATOR;
      // hardware switching after writes, so it always wins
      if (s_fail && uses_ext)
      begin
         next_clk_cfg.root_src = SRC_INTERNAL_FAST_OSCILLATOR;
         next_css_flag         = 1'b1;
      end
      // fast oscillators were off in stop, so restart on the internal one
      if (state == ST_STOP && next_state == ST_RUN)
         next_clk_cfg.root_src = SRC_INTERNAL_FAST_OSCILLATOR;
      if (soft_rst)
      begin
         next_clk_cfg  = CLKCFG_RST;
         next_lp_cfg   = LPCFG_RST;
         next_css_flag = 1'b0;
      end
      if (i_rd)
      begin
         if (i_addr == OFS_CLKCFG)
            next_rdata = 32'(clk_cfg);
         else if (i_addr == OFS_LPCFG)
            next_rdata = 32'(lp_cfg);
         else if (i_addr == OFS_STATUS)
            next_rdata = 32'(status);
         else
            next_rdata = '0;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_external_reset_pin)
      begin
         clk_cfg  <= CLKCFG_RST;
         lp_cfg   <= LPCFG_RST;
         css_flag <= 1'b0;
         o_rdata  <= '0;
      end
      else
      begin
         clk_cfg  <= next_clk_cfg;
         lp_cfg   <= next_lp_cfg;
         css_flag <= next_css_flag;
         o_rdata  <= next_rdata;
      end
   end

   // -------------------------------------------------------------------
   // power and reset outputs
   // -------------------------------------------------------------------
   pmcc_pwr_t next_pwr;
   logic      next_ext_need;

   always_comb
   begin
      next_ext_need = (next_clk_cfg.root_src ==
                       SRC_EXTERNAL_FAST_OSCILLATOR) ||
                      (next_clk_cfg.root_src == SRC_MULTIPLIER_LOOP_CLOCK &&
                       next_clk_cfg.pll_src_ext);
      next_pwr = '{core_clk_en: 1'b1, domain_clk_en: 1'b1,
                   core_power: 1'b1, retain: 1'b1, int_osc_en: 1'b1,
                   ext_osc_en: 1'b0, loop_en: 1'b0,
                   regulator: REG_MAIN_REGULATOR_MODE};
      case (next_state)
         ST_RESET:
         begin
            next_pwr.core_clk_en   = 1'b0;
            next_pwr.domain_clk_en = 1'b0;
         end
         ST_SLEEP:
            next_pwr.core_clk_en = 1'b0;
         ST_STOP:
         begin
            next_pwr.core_clk_en   = 1'b0;
            next_pwr.domain_clk_en = 1'b0;
            next_pwr.int_osc_en    = 1'b0;
            next_pwr.regulator     = lp_cfg.stop_lpr ?
                                     REG_LOW_POWER_REGULATOR_MODE :
                                     REG_MAIN_REGULATOR_MODE;
         end
         ST_STANDBY:
         begin
            next_pwr.core_clk_en   = 1'b0;
            next_pwr.domain_clk_en = 1'b0;
            next_pwr.core_power    = 1'b0;
            next_pwr.retain        = 1'b0;
            next_pwr.int_osc_en    = 1'b0;
            next_pwr.regulator     = REG_HIGH_IMPEDANCE;
         end
         default:
            next_pwr.core_clk_en = 1'b1;
      endcase
      if (next_pwr.domain_clk_en)
      begin
         next_pwr.ext_osc_en = next_ext_need;
         next_pwr.loop_en    = (next_clk_cfg.root_src ==
                                SRC_MULTIPLIER_LOOP_CLOCK);
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_external_reset_pin)
      begin
         o_sys_rst_n <= 1'b0;
         o_pwr       <= '{core_clk_en: 1'b0, domain_clk_en: 1'b0,
                          core_power: 1'b1, retain: 1'b1,
                          int_osc_en: 1'b1, ext_osc_en: 1'b0,
                          loop_en: 1'b0,
                          regulator: REG_MAIN_REGULATOR_MODE};
         o_clk_cfg   <= CLKCFG_RST;
         o_css_irq   <= 1'b0;
      end
      else
      begin
         o_sys_rst_n <= (next_state != ST_RESET);
         o_pwr       <= next_pwr;
         o_clk_cfg   <= next_clk_cfg;
         o_css_irq   <= next_css_flag & next_lp_cfg.css_ie;
      end
   end

   // -------------------------------------------------------------------
   // bus prescalers
   // -------------------------------------------------------------------
   pmcc_div #(.W(4)) u_ahb_div
   (
      .i_clk  (i_clk),
      .i_external_reset_pin (i_external_reset_pin),
      .i_en   (o_pwr.domain_clk_en),
      .i_div  (clk_cfg.ahb_div),
      .o_tick (o_ahb_tick)
   );

   pmcc_div #(.W(3)) u_apb1_div
   (
      .i_clk  (i_clk),
      .i_external_reset_pin (i_external_reset_pin),
      .i_en   (o_ahb_tick),
      .i_div  (clk_cfg.apb1_div),
      .o_tick (o_apb1_tick)
   );

   pmcc_div #(.W(3)) u_apb2_div
   (
      .i_clk  (i_clk),
      .i_external_reset_pin (i_external_reset_pin),
      .i_en   (o_ahb_tick),
      .i_div  (clk_cfg.apb2_div),
      .o_tick (o_apb2_tick)
   );

endmodule // pmcc_top

`default_nettype wire

// [pmcc_chk.sv]
// checker on the pmcc_top ports: reset hold, regulator, wake, clocks.
// assumes pmcc_pkg is compiled first; bound into every pmcc_top.
`timescale 1ns/100ps
`default_nettype none

module pmcc_chk
(
   // clock and reset
   input wire logic                        i_clk,
   input wire logic                        i_external_reset_pin,
   // events
   input wire logic                        i_supply_low,
   input wire logic                        i_rtc_event,
   input wire logic                        i_ext_osc_fail,
   input wire logic                        i_irq_event,
   input wire logic [pmcc_pkg::LINES-1:0]  i_ext_lines,
   // watched outputs
   input wire logic                        o_sys_rst_n,
   input wire pmcc_pkg::pmcc_pwr_t         o_pwr,
   input wire pmcc_pkg::pmcc_clk_cfg_t     o_clk_cfg,
   input wire logic                        o_ahb_tick,
   input wire logic                        o_apb1_tick
);
   import pmcc_pkg::*;

   logic in_sleep;
   logic in_stop;
   logic in_stby;
   logic ext_root;
   assign in_sleep = o_sys_rst_n && !o_pwr.core_clk_en && o_pwr.domain_clk_en;
   assign in_stop  = o_sys_rst_n && !o_pwr.domain_clk_en && o_pwr.core_power;
   assign in_stby  = o_pwr.regulator == REG_HIGH_IMPEDANCE;
   assign ext_root = o_clk_cfg.root_src == SRC_EXTERNAL_FAST_OSCILLATOR;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_external_reset_pin);

   // -------------------------------------------------------------------
   // properties
   // -------------------------------------------------------------------
   // pins pass two sync flops, so three samples precede any reaction
   supply_hold_a: assert property (i_supply_low [*4] |=> !o_sys_rst_n)
      else $error("reset released while supply low");
   run_reg_a: assert property (o_pwr.core_clk_en |-> !o_pwr.regulator)
      else $error("regulator not main while running");
   stop_keep_a: assert property (in_stop |-> o_pwr.retain && !in_stby
      && !o_pwr.int_osc_en && !o_pwr.ext_osc_en && !o_pwr.loop_en)
      else $error("stop left an oscillator on or lost data");
   sleep_wake_a: assert property ((in_sleep && i_irq_event) [*3]
      |=> o_pwr.core_clk_en)
      else $error("sleep did not end on event");
   stop_wake_a: assert property ((in_stop &&
      (|i_ext_lines || i_rtc_event)) [*3]
      |=> o_pwr.domain_clk_en && !o_clk_cfg.root_src)
      else $error("stop did not end on line or calendar");
   stby_off_a: assert property (in_stby |-> !o_pwr.core_power
      && !o_pwr.domain_clk_en && !o_pwr.int_osc_en && !o_pwr.ext_osc_en
      && !o_pwr.loop_en)
      else $error("standby left core power or clocks on");
   stby_wake_a: assert property ((in_stby && i_rtc_event) [*3]
      |=> !in_stby ##1 !o_sys_rst_n)
      else $error("standby did not wake through reset");
   root_reset_a: assert property ($rose(o_sys_rst_n) |->
      o_clk_cfg == CLKCFG_RST && o_pwr.regulator == REG_MAIN_REGULATOR_MODE)
      else $error("reset left clock setup or regulator off default");
   css_swap_a: assert property ((i_ext_osc_fail && ext_root) [*3]
      |=> o_clk_cfg.root_src == SRC_INTERNAL_FAST_OSCILLATOR)
      else $error("oscillator failure kept external root");
   ahb_gap_a: assert property (o_ahb_tick && o_clk_cfg.ahb_div == 4'h2
      && o_pwr.domain_clk_en |=> (!o_ahb_tick || $changed(o_clk_cfg)) [*2])
      else $error("bus tick spacing wrong");
   apb_follow_a: assert property (o_apb1_tick |-> $past(o_ahb_tick))
      else $error("peripheral tick without bus tick");
endmodule // pmcc_chk

bind pmcc_top pmcc_chk u_chk
(
   .i_clk(i_clk), .i_external_reset_pin(i_external_reset_pin), .i_supply_low(i_supply_low),
   .i_rtc_event(i_rtc_event), .i_ext_osc_fail(i_ext_osc_fail),
   .i_irq_event(i_irq_event), .i_ext_lines(i_ext_lines),
   .o_sys_rst_n(o_sys_rst_n), .o_pwr(o_pwr), .o_clk_cfg(o_clk_cfg),
   .o_ahb_tick(o_ahb_tick), .o_apb1_tick(o_apb1_tick)
);

`default_nettype wire

// [pmcc_core.sv]
// core model: raises the low-power request on command, after a delay.
// assumes the bench commands it only while the block is running.
`timescale 1ns/100ps
`default_nettype none

module pmcc_core_model
(
   // clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_external_reset_pin,
   // command
   input  wire logic       i_go,
   input  wire logic [3:0] i_delay,
   // request
   output logic            o_lp_req
);
   logic       armed;
   logic [3:0] cnt;

   // one single-cycle request per command, so never two in one run period
   always_ff @(posedge i_clk)
   begin
      o_lp_req <= i_external_reset_pin && armed && cnt == 4'h0;
      armed    <= i_external_reset_pin && (i_go || (armed && cnt != 4'h0));
      cnt      <= i_go ? i_delay : cnt - 4'(armed && cnt != 4'h0);
   end
endmodule // pmcc_core_model

`default_nettype wire

// [tb_power_mode_and_clock_control.sv]
// self-checking bench for pmcc_top, core model issuing mode requests.
// assumes pmcc_pkg, pmcc_top, the checker and the core model compiled.
`timescale 1ns/100ps
`default_nettype none

module tb_power_mode_and_clock_control;
   import pmcc_pkg::*;

   logic          clk, external_reset_pin, wr, rd, lp_req, sup_low, pin_n, wdog;
   logic          wake, rtc, fail, irq, go, sys_n, css, t_ahb, t_apb1;
   logic          t_apb2;
   logic [3:0]    dly;
   logic [7:0]    addr;
   logic [15:0]   lines;
   logic [31:0]   wdata, rdata, d;
   pmcc_pwr_t     pwr;
   pmcc_clk_cfg_t cfg;
   int            bad_count, samples_checked;

   pmcc_top DUT
   (
      .i_clk(clk), .i_external_reset_pin(external_reset_pin), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_lp_req(lp_req),
      .i_supply_low(sup_low), .i_external_reset_pin_n(pin_n),
      .i_independent_watchdog(wdog), .i_wake_pin(wake),
      .i_rtc_event(rtc), .i_ext_osc_fail(fail), .i_irq_event(irq),
      .i_ext_lines(lines), .o_sys_rst_n(sys_n), .o_pwr(pwr),
      .o_clk_cfg(cfg), .o_css_irq(css), .o_ahb_tick(t_ahb),
      .o_apb1_tick(t_apb1), .o_apb2_tick(t_apb2)
   );
   pmcc_core_model u_core
   (
      .i_clk(clk), .i_external_reset_pin(external_reset_pin), .i_go(go), .i_delay(dly), .o_lp_req(lp_req)
   );

   always #4 clk = ~clk;

   // -------------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic stop_test();
      $display("checks=%0d errors=%0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      wr    <= 1'h1;
      addr  <= a;
      wdata <= v;
      @(posedge clk);
      wr    <= 1'h0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic bus_rd(input logic [7:0] a);
      @(posedge clk);
      rd   <= 1'h1;
      addr <= a;
      @(posedge clk);
      rd   <= 1'h0;
      @(posedge clk);
      d = rdata;
   endtask

   // a low-power wait does not care about the reset output
   task automatic wait_core(input logic want, input int lim);
      int n;
      for (n = 0; n < lim && !(pwr.core_clk_en === want
           && (sys_n === 1'h1 || !want)); n++) @(posedge clk);
      if (n >= lim)
      begin
         bad_count++;
         stop_test();
      end
   endtask

   // tick counts packed as ahb, apb1, apb2 bytes
   task automatic ticks(input int n, output logic [31:0] s);
      s = '0;
      repeat (n) @(posedge clk) s += 32'({8'(t_ahb), 8'(t_apb1), 8'(t_apb2)});
   endtask

   task automatic lp_enter(input pmcc_lp_t m, input logic low_power_regulator_mode,
                           input logic [3:0] dl);
      bus_wr(OFS_LPCFG, 32'({low_power_regulator_mode, m}));
      dly <= dl;
      go  <= 1'h1;
      @(posedge clk);
      go  <= 1'h0;
      wait_core(1'h0, 40);
      // a peripheral tick may still trail the last bus tick
      cyc(1);
   endtask

   // -------------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------------
   task automatic t_clk_css();
      for (int s = 0; s < 4; s++)
      begin
         bus_wr(OFS_CLKCFG, 32'(s));
         bus_rd(OFS_STATUS);
         chk(32'(cfg.root_src), 32'(s % 3));
         chk(32'(d[3:2]), 32'(s % 3));
         chk(32'({pwr.ext_osc_en, pwr.loop_en}), 32'({s==1, s==2}));
      end
      bus_wr(OFS_LPCFG, 32'h0000_0008);
      for (int k = 0; k < 2; k++)
      begin
         bus_wr(OFS_CLKCFG, k ? 32'h0000_0006 : 32'h0000_0001);
         fail <= 1'h1;
         cyc(5);
         chk(32'({cfg.root_src, css}), 32'h0000_0001);
         fail <= 1'h0;
         cyc(3);
         bus_wr(OFS_STATUS, 32'h0000_0001);
         cyc(1);
         chk(32'(css), '0);
      end
   endtask

   task automatic t_sleep_stop();
      logic [31:0] s;
      bus_wr(OFS_CLKCFG, 32'h000C_9000);
      cyc(20);
      ticks(60, s);
      chk(s, 32'h0014_0A05);
      lp_enter(LP_SLEEP, 1'h0, 4'h5);
      ticks(30, s);
      chk(32'(s[23:16]), 32'h0000_000A);
      irq <= 1'h1;
      wait_core(1'h1, 6);
      irq <= 1'h0;
      cyc(3);
      for (int i = 0; i < 17; i++)
      begin
         bus_wr(OFS_CLKCFG, 32'h000C_9001);
         lp_enter(LP_STOP, i[0], 4'h0);
         chk(32'(pwr.regulator), 32'(i[0]));
         chk(32'({pwr.retain, pwr.int_osc_en, pwr.ext_osc_en, pwr.loop_en,
                  pwr.domain_clk_en}), 32'h0000_0010);
         ticks(9, s);
         chk(s, '0);
         if (i < 16)
            lines <= 16'(1 << i);
         else
            rtc <= 1'h1;
         wait_core(1'h1, 6);
         chk(32'(cfg.root_src), '0);
         lines <= '0;
         rtc   <= 1'h0;
         cyc(3);
      end
   endtask

   task automatic t_standby();
      int n;
      for (int c = 0; c < 4; c++)
      begin
         bus_wr(OFS_CLKCFG, 32'h000C_9002);
         lp_enter(LP_STANDBY, 1'h0, 4'h0);
         chk(32'({pwr.regulator, pwr.core_power, pwr.int_osc_en,
                  pwr.ext_osc_en, pwr.loop_en}), 32'h0000_0020);
         wake  <= c == 0;
         rtc   <= c == 1;
         pin_n <= c != 2;
         wdog  <= c == 3;
         for (n = 0; n < 8 && sys_n !== 1'h0; n++) @(posedge clk);
         chk(32'(sys_n), '0);
         wake  <= 1'h0;
         rtc   <= 1'h0;
         pin_n <= 1'h1;
         wdog  <= 1'h0;
         wait_core(1'h1, 300);
         bus_rd(OFS_LPCFG);
         chk(d | 32'(cfg), '0);
         bus_rd(OFS_STATUS);
         chk(d, 32'h0000_0012);
      end
   endtask

   initial
   begin
      {clk, external_reset_pin, wr, rd, sup_low, wdog, wake, rtc, fail, irq, go} = '0;
      {dly, addr, lines, wdata} = '0;
      pin_n = 1'h1;
      bad_count = 0;
      samples_checked = 0;
      cyc(12);
      external_reset_pin <= 1'h1;
      wait_core(1'h1, 300);
      chk(32'({cfg, pwr.regulator}), '0);
      bus_rd(OFS_STATUS);
      chk(d, 32'({ST_RUN, SRC_INTERNAL_FAST_OSCILLATOR, 2'h0}));
      bus_rd(8'h0C);
      chk(d, '0);
      t_clk_css();
      t_sleep_stop();
      t_standby();
      // supply low must hold reset however long it lasts
      sup_low <= 1'h1;
      ticks(205, d);
      chk(32'(sys_n), '0);
      sup_low <= 1'h0;
      wait_core(1'h1, 300);
      stop_test();
   end
endmodule // tb_power_mode_and_clock_control

`default_nettype wire
